// >>> hw/sbdmu_unit.sv
// execute slice: subtract with carry, field extract, divide, event hint, long multiply
// assumes one issue per cycle; operands already read; results one edge later
//
// Behaviour
// - immediate form: Rn plus inverted constant plus carry
// - constant from modified expansion; S selects flags
// - flags: N bit31, Z zero, C carry, V overflow
// - 16-bit: Rdn both, no shift, flags outside block
// - register form shifts Rm, carry feeds shifter
// - 32-bit: register 13 or 15 unpredictable
// - extract field, sign extend to 32 bits
// - lsb from imm3:imm2; top above 31 unpredictable
// - signed divide quotient, flags untouched
// - event hint pulses event to all processors
// - event hint otherwise no register or flag effect
// - multiply-accumulate long into high/low pair
// - multiply long writes 64-bit product halves
// - long multiplies: no flags; equal halves unpredictable
module sbdmu_unit
   import sbdmu_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic issue_valid,
   input wire sbdmu_op_type op,
   input wire logic enc32,
   input wire logic cond_pass,
   input wire logic in_conditional_block,
   input wire logic set_flags_bit,
   input wire logic [3:0] rd,
   input wire logic [3:0] rn,
   input wire logic [3:0] rm,
   input wire logic [3:0] low_result_reg,
   input wire logic [3:0] high_result_reg,
   input wire logic [11:0] imm12,
   input wire logic [1:0] shift_type,
   input wire logic [4:0] shift_imm,
   input wire logic [4:0] field_width_less_one,
   input wire logic [31:0] op_a,
   input wire logic [31:0] op_b,
   input wire logic [31:0] acc_hi,
   input wire logic [31:0] acc_lo,
   input wire logic [3:0] program_status_flags,
   input wire logic div_trap_enable,
   output logic result_valid_reg,
   output logic [31:0] res_lo_reg,
   output logic [31:0] res_hi_reg,
   output logic [3:0] dest_lo_reg,
   output logic [3:0] dest_hi_reg,
   output logic wr_lo_reg,
   output logic wr_hi_reg,
   output logic [3:0] flags_out_reg,
   output logic flags_wr_reg,
   output logic unpredictable_reg,
   output logic div_zero_fault_reg,
   output logic send_event_reg
);
   logic [31:0] imm32;
   logic imm_bad;
   logic [31:0] shifted;
   logic [31:0] sub_operand;
   logic [32:0] sum33;
   logic sub_ovf;
   logic [5:0] msb;
   logic [31:0] field_val;
   logic [31:0] quot;
   logic [63:0] prod;
   logic [63:0] mac;
   logic execute;
   logic is_sub;
   logic is_long;
   logic reg_bad;
   logic [31:0] res_lo_next;
   logic [31:0] res_hi_next;
   logic flags_wr_next;

   sbdmu_imm_expand u_imm (
      .imm12(imm12),
      .imm32(imm32),
      .bad(imm_bad)
   );

   function automatic logic is_banned(input logic [3:0] r);
      is_banned = (r == REG_STACK) || (r == REG_PROG);
   endfunction : is_banned

   // immediate shift decode: zero amount means 32 for right shifts, rrx for rotate
   always_comb begin
      shifted = op_b;
      if (enc32) begin
         case (shift_type)
            SHIFT_LSL: shifted = op_b << shift_imm;
            SHIFT_LSR: shifted = (shift_imm == 5'h00) ? 32'h00000000 : op_b >> shift_imm;
            SHIFT_ASR: shifted = (shift_imm == 5'h00) ? {32{op_b[31]}} :
               32'($signed(op_b) >>> shift_imm);
            default: shifted = (shift_imm == 5'h00) ?
               {program_status_flags[FLAG_C], op_b[31:1]} :
               (op_b >> shift_imm) | (op_b << (6'h20 - {1'b0, shift_imm}));
         endcase
      end
   end

   always_comb begin
      sub_operand = (op == op_subtract_with_carry_imm) ? imm32 : shifted;
      sum33 = {1'b0, op_a} + {1'b0, ~sub_operand} +
         {32'h00000000, program_status_flags[FLAG_C]};
      sub_ovf = (op_a[31] == ~sub_operand[31]) && (sum33[31] != op_a[31]);
   end

   always_comb begin
      msb = {1'b0, shift_imm} + {1'b0, field_width_less_one};
      // push the field to the top, then arithmetic shift back down
      field_val = 32'($signed(op_a << (TOP_BIT - msb)) >>>
         (5'h1F - field_width_less_one));
   end

   always_comb begin
      if (op_b == 32'h00000000) begin
         quot = 32'h00000000;
      end else if (op_a == MOST_NEGATIVE && op_b == MINUS_ONE) begin
         quot = MOST_NEGATIVE;
      end else begin
         quot = 32'($signed(op_a) / $signed(op_b));
      end
   end

   always_comb begin
      // widen before multiplying so the product keeps all 64 bits
      prod = $signed({{32{op_a[31]}}, op_a}) * $signed({{32{op_b[31]}}, op_b});
      mac = prod + {acc_hi, acc_lo};
   end

   always_comb begin
      execute = issue_valid && cond_pass;
      is_sub = (op == op_subtract_with_carry_imm) || (op == op_subtract_with_carry_reg);
      is_long = (op == op_signed_mul_long) || (op == op_signed_mul_acc_long);
      reg_bad = 1'b0;
      if (enc32) begin
         case (op)
            op_subtract_with_carry_imm: reg_bad = is_banned(rd) || is_banned(rn) || imm_bad;
            op_subtract_with_carry_reg, op_signed_divide:
               reg_bad = is_banned(rd) || is_banned(rn) || is_banned(rm);
            op_signed_field_extract: reg_bad = is_banned(rd) || is_banned(rn) || msb > TOP_BIT;
            op_signed_mul_long, op_signed_mul_acc_long:
               reg_bad = is_banned(low_result_reg) || is_banned(high_result_reg) ||
                  is_banned(rn) || is_banned(rm) ||
                  (low_result_reg == high_result_reg);
            default: reg_bad = 1'b0;
         endcase
      end
      // 16-bit form takes flags from block state, 32-bit from S
      flags_wr_next = execute && is_sub &&
         (enc32 ? set_flags_bit : !in_conditional_block);
      res_hi_next = 32'h00000000;
      case (op)
         op_subtract_with_carry_imm, op_subtract_with_carry_reg: res_lo_next = sum33[31:0];
         op_signed_field_extract: res_lo_next = field_val;
         op_signed_divide: res_lo_next = quot;
         op_signed_mul_long: begin
            res_lo_next = prod[31:0];
            res_hi_next = prod[63:32];
         end
         op_signed_mul_acc_long: begin
            res_lo_next = mac[31:0];
            res_hi_next = mac[63:32];
         end
         default: res_lo_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         result_valid_reg <= 1'b0;
         res_lo_reg <= 32'h00000000;
         res_hi_reg <= 32'h00000000;
         dest_lo_reg <= 4'h0;
         dest_hi_reg <= 4'h0;
         wr_lo_reg <= 1'b0;
         wr_hi_reg <= 1'b0;
         unpredictable_reg <= 1'b0;
      end else begin
         result_valid_reg <= issue_valid;
         res_lo_reg <= res_lo_next;
         res_hi_reg <= res_hi_next;
         // 16-bit register form writes back to rd, which also named the first operand
         dest_lo_reg <= is_long ? low_result_reg : rd;
         dest_hi_reg <= high_result_reg;
         wr_lo_reg <= execute && (op != op_none) && (op != op_send_event_hint) &&
            !(op == op_signed_divide && op_b == 32'h00000000 && div_trap_enable);
         wr_hi_reg <= execute && is_long;
         unpredictable_reg <= issue_valid && reg_bad;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         flags_out_reg <= FLAGS_RESET;
         flags_wr_reg <= 1'b0;
      end else begin
         flags_wr_reg <= flags_wr_next;
         if (flags_wr_next) begin
            flags_out_reg <= {sum33[31], sum33[31:0] == 32'h00000000,
               sum33[32], sub_ovf};
         end else begin
            flags_out_reg <= program_status_flags;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         div_zero_fault_reg <= 1'b0;
         send_event_reg <= 1'b0;
      end else begin
         div_zero_fault_reg <= execute && (op == op_signed_divide) &&
            (op_b == 32'h00000000) && div_trap_enable;
         send_event_reg <= execute && (op == op_send_event_hint);
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   AST_SUB_IMM_SUM: assert property (
      execute && op == op_subtract_with_carry_imm |=>
         res_lo_reg == $past(op_a + ~imm32 + {31'h00000000, program_status_flags[FLAG_C]})
   ) else $error("immediate subtract result wrong");
   AST_FLAG_VALUES: assert property (
      flags_wr_reg |-> flags_out_reg[FLAG_N] == res_lo_reg[31] &&
         flags_out_reg[FLAG_Z] == (res_lo_reg == 32'h00000000)
   ) else $error("subtract flags disagree with result");
   AST_SHORT_IN_BLOCK: assert property (
      issue_valid && op == op_subtract_with_carry_reg && !enc32 && in_conditional_block
         |=> !flags_wr_reg
   ) else $error("short form updated flags inside block");
   AST_BANNED_REG: assert property (
      issue_valid && enc32 && op != op_none && op != op_send_event_hint &&
         (rn == REG_STACK || rn == REG_PROG) |=> unpredictable_reg
   ) else $error("banned register not flagged");
   AST_DIV_NO_FLAGS: assert property (
      issue_valid && op == op_signed_divide |=> !flags_wr_reg ##1 1'b1
   ) else $error("divide touched flags");
   AST_DIV_ZERO: assert property (
      execute && op == op_signed_divide && op_b == 32'h00000000 |=>
         res_lo_reg == 32'h00000000 && div_zero_fault_reg == $past(div_trap_enable) &&
         wr_lo_reg != $past(div_trap_enable)
   ) else $error("zero divisor handling wrong");
   AST_EVENT_PULSE: assert property (
      execute && op == op_send_event_hint |=> send_event_reg && !wr_lo_reg && !flags_wr_reg
   ) else $error("event hint missing or had side effects");
   AST_MUL_LONG: assert property (
      execute && op == op_signed_mul_long |=> {res_hi_reg, res_lo_reg} == $past(prod) &&
         wr_hi_reg && wr_lo_reg
   ) else $error("long product wrong");
   AST_SAME_HALVES: assert property (
      issue_valid && enc32 && is_long && low_result_reg == high_result_reg |=>
         unpredictable_reg && !flags_wr_reg
   ) else $error("equal result halves not flagged");
   AST_COND_FAIL: assert property (
      issue_valid && !cond_pass |=> !wr_lo_reg && !wr_hi_reg && !flags_wr_reg &&
         !send_event_reg && !div_zero_fault_reg
   ) else $error("failed condition had an effect");

   COV_SUB_FLAGS: cover property (flags_wr_reg && flags_out_reg[FLAG_V]);
   COV_MAC: cover property (execute && op == op_signed_mul_acc_long ##1 wr_hi_reg);
   COV_DIV_TRAP: cover property (div_zero_fault_reg);
   COV_EVENT: cover property (send_event_reg);
endmodule : sbdmu_unit

// >>> hw/sbdmu_pkg.sv
// constants and types for the subtract/extract/divide/multiply slice
// assumes the front end hands over decoded fields and operand values
package sbdmu_pkg;
   localparam logic [3:0] REG_STACK = 4'hD;
   localparam logic [3:0] REG_PROG = 4'hF;
   localparam int FLAG_N = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_C = 1;
   localparam int FLAG_V = 0;
   localparam logic [1:0] SHIFT_LSL = 2'h0;
   localparam logic [1:0] SHIFT_LSR = 2'h1;
   localparam logic [1:0] SHIFT_ASR = 2'h2;
   localparam logic [1:0] SHIFT_ROR = 2'h3;
   localparam logic [31:0] MOST_NEGATIVE = 32'h80000000;
   localparam logic [31:0] MINUS_ONE = 32'hFFFFFFFF;
   localparam logic [5:0] TOP_BIT = 6'h1F;
   localparam logic [3:0] FLAGS_RESET = 4'h0;

   typedef enum logic [2:0] {
      op_none = 3'h0,
      op_subtract_with_carry_imm = 3'h1,
      op_subtract_with_carry_reg = 3'h3,
      op_signed_field_extract = 3'h2,
      op_signed_divide = 3'h6,
      op_send_event_hint = 3'h7,
      op_signed_mul_acc_long = 3'h5,
      op_signed_mul_long = 3'h4
   } sbdmu_op_type;
endpackage : sbdmu_pkg

// >>> hw/sbdmu_imm_expand.sv
// modified_immediate_expand: 12-bit packed constant to 32 bits
// assumes imm12 is {i, imm3, imm8} as decoded by the front end
module sbdmu_imm_expand
   import sbdmu_pkg::*;
(
   input wire logic [11:0] imm12,
   output logic [31:0] imm32,
   output logic bad
);
   logic [31:0] unrot;
   logic [4:0] rot;

   always_comb begin
      unrot = {24'h000000, 1'b1, imm12[6:0]};
      rot = imm12[11:7];
      bad = 1'b0;
      imm32 = (unrot >> rot) | (unrot << (6'h20 - {1'b0, rot}));
      if (imm12[11:10] == 2'h0) begin
         case (imm12[9:8])
            2'h0: imm32 = {24'h000000, imm12[7:0]};
            2'h1: imm32 = {8'h00, imm12[7:0], 8'h00, imm12[7:0]};
            2'h2: imm32 = {imm12[7:0], 8'h00, imm12[7:0], 8'h00};
            default: imm32 = {4{imm12[7:0]}};
         endcase
         // replicated patterns of a zero byte are not a legal encoding
         bad = (imm12[9:8] != 2'h0) && (imm12[7:0] == 8'h00);
      end
   end
endmodule : sbdmu_imm_expand

// >>> test/test_sbdmu_unit.sv
// self-checking bench for the subtract, extract, divide, event and long multiply slice
// assumes sbdmu_pkg is compiled first; the bench drives every sbdmu_unit input itself
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_sbdmu_unit
   import sbdmu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   int errors = 0;
   int n_checks = 0;
   logic mclk, reset, issue_valid, enc32, cond_pass, in_conditional_block, set_flags_bit;
   logic div_trap_enable;
   sbdmu_op_type op;
   logic [3:0] rd, rn, rm, low_result_reg, high_result_reg, program_status_flags;
   logic [11:0] imm12;
   logic [1:0] shift_type;
   logic [4:0] shift_imm, field_width_less_one;
   logic [31:0] op_a, op_b, acc_hi, acc_lo, res_lo_reg, res_hi_reg;
   logic result_valid_reg, wr_lo_reg, wr_hi_reg, flags_wr_reg, unpredictable_reg;
   logic div_zero_fault_reg, send_event_reg;
   logic [3:0] dest_lo_reg, dest_hi_reg, flags_out_reg;
   logic [6:0] ctl_out;
   assign ctl_out = {result_valid_reg, wr_lo_reg, wr_hi_reg, flags_wr_reg, unpredictable_reg,
      div_zero_fault_reg, send_event_reg};

   sbdmu_unit dut (.mclk, .reset, .issue_valid, .op, .enc32, .cond_pass, .in_conditional_block,
      .set_flags_bit, .rd, .rn, .rm, .low_result_reg, .high_result_reg, .imm12, .shift_type,
      .shift_imm, .field_width_less_one, .op_a, .op_b, .acc_hi, .acc_lo, .program_status_flags,
      .div_trap_enable, .result_valid_reg, .res_lo_reg, .res_hi_reg, .dest_lo_reg, .dest_hi_reg,
      .wr_lo_reg, .wr_hi_reg, .flags_out_reg, .flags_wr_reg, .unpredictable_reg,
      .div_zero_fault_reg, .send_event_reg);

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // idle inputs; regs lo=4 hi=5
   task automatic defaults();
      op <= op_none;
      issue_valid <= 1'b0;
      {enc32, cond_pass, in_conditional_block, set_flags_bit, div_trap_enable} <= 5'h18;
      {rd, rn, rm, low_result_reg, high_result_reg} <= 20'h12345;
      {shift_type, shift_imm, field_width_less_one, imm12} <= 24'h0;
      {op_a, op_b, acc_hi, acc_lo} <= 128'h0;
      program_status_flags <= 4'h0;
   endtask : defaults

   // ctl = {valid, wr_lo, wr_hi, flags_wr, unpredictable, fault, event}
   task automatic run(input sbdmu_op_type o, input logic [31:0] hi, input logic [31:0] lo,
      input logic [3:0] fl, input logic [6:0] ctl);
      op <= o;
      issue_valid <= 1'b1;
      @(posedge mclk);
      defaults();
      #1;
      if (ctl[2]) begin
         `CHK(unpredictable_reg, 1'b1)
      end else begin
         `CHK(ctl_out, ctl)
         `CHK(flags_out_reg, fl)
      end
      if (ctl[5] && !ctl[2]) begin
         `CHK({res_hi_reg, res_lo_reg}, {hi, lo})
      end
      if (ctl[5] && !ctl[4] && !ctl[2]) begin
         `CHK(dest_lo_reg, 4'h1)
      end
      if (ctl[4] && !ctl[2]) begin
         `CHK({dest_hi_reg, dest_lo_reg}, 8'h54)
      end
      @(posedge mclk);
   endtask : run

   task automatic t_sub_imm();
      {imm12, op_a, program_status_flags, set_flags_bit} <= {12'h001, 32'h5, 4'h2, 1'b1};
      run(op_subtract_with_carry_imm, 32'h0, 32'h4, 4'h2, 7'h68);
      {imm12, op_a, program_status_flags, set_flags_bit} <= {12'h4FF, 32'h7F800000, 4'h2, 1'b1};
      run(op_subtract_with_carry_imm, 32'h0, 32'h0, 4'h6, 7'h68);
      {imm12, op_a, program_status_flags} <= {12'h1AB, 32'h00AB00AC, 4'h2};
      run(op_subtract_with_carry_imm, 32'h0, 32'h1, 4'h2, 7'h60);
      {imm12, op_a, program_status_flags} <= {12'h2AB, 32'hAB00AB00, 4'h2};
      run(op_subtract_with_carry_imm, 32'h0, 32'h0, 4'h2, 7'h60);
      {imm12, op_a, program_status_flags} <= {12'h3AB, 32'hABABABAC, 4'h2};
      run(op_subtract_with_carry_imm, 32'h0, 32'h1, 4'h2, 7'h60);
   endtask : t_sub_imm

   task automatic t_sub_reg();
      {op_a, op_b, program_status_flags, set_flags_bit} <= {32'h20, 32'h1, 4'h2, 1'b1};
      shift_imm <= 5'h4;
      run(op_subtract_with_carry_reg, 32'h0, 32'h10, 4'h2, 7'h68);
      {op_b, shift_type, shift_imm} <= {32'h80000000, SHIFT_LSR, 5'h1F};
      {op_a, set_flags_bit} <= {32'h1, 1'b1};
      run(op_subtract_with_carry_reg, 32'h0, 32'hFFFFFFFF, 4'h8, 7'h68);
      {op_b, shift_type, shift_imm} <= {32'h80000000, SHIFT_ASR, 5'h1};
      {program_status_flags, set_flags_bit} <= {4'h2, 1'b1};
      run(op_subtract_with_carry_reg, 32'h0, 32'h40000000, 4'h0, 7'h68);
      {op_a, op_b, shift_type} <= {32'h80000001, 32'h3, SHIFT_ROR};
      {program_status_flags, set_flags_bit} <= {4'h2, 1'b1};
      run(op_subtract_with_carry_reg, 32'h0, 32'h0, 4'h6, 7'h68);
      {op_b, shift_type, shift_imm} <= {32'h1, SHIFT_ROR, 5'h1};
      run(op_subtract_with_carry_reg, 32'h0, 32'h7FFFFFFF, 4'h0, 7'h60);
      {enc32, op_a, op_b, shift_imm} <= {1'b0, 32'h80000000, 32'h1, 5'h4};
      program_status_flags <= 4'h2;
      run(op_subtract_with_carry_reg, 32'h0, 32'h7FFFFFFF, 4'h3, 7'h68);
      {enc32, in_conditional_block, op_a, op_b} <= {2'h1, 32'h80000000, 32'h1};
      program_status_flags <= 4'h2;
      run(op_subtract_with_carry_reg, 32'h0, 32'h7FFFFFFF, 4'h2, 7'h60);
   endtask : t_sub_reg

   task automatic t_extract();
      {op_a, shift_imm, field_width_less_one} <= {32'h00000F00, 5'h8, 5'h3};
      run(op_signed_field_extract, 32'h0, 32'hFFFFFFFF, 4'h0, 7'h60);
      {op_a, shift_imm, field_width_less_one} <= {32'h80000F00, 5'h8, 5'h4};
      run(op_signed_field_extract, 32'h0, 32'hF, 4'h0, 7'h60);
      {op_a, shift_imm, field_width_less_one} <= {32'h80000000, 5'h1F, 5'h0};
      run(op_signed_field_extract, 32'h0, 32'hFFFFFFFF, 4'h0, 7'h60);
      {shift_imm, field_width_less_one} <= {5'h1E, 5'h2};
      run(op_signed_field_extract, 32'h0, 32'h0, 4'h0, 7'h04);
   endtask : t_extract

   task automatic t_divide();
      {op_a, op_b, program_status_flags} <= {32'hFFFFFFF9, 32'h2, 4'hF};
      run(op_signed_divide, 32'h0, 32'hFFFFFFFD, 4'hF, 7'h60);
      {op_a, op_b} <= {MOST_NEGATIVE, MINUS_ONE};
      run(op_signed_divide, 32'h0, 32'h80000000, 4'h0, 7'h60);
      {op_a, div_trap_enable} <= {32'h5, 1'b1};
      run(op_signed_divide, 32'h0, 32'h0, 4'h0, 7'h42);
      op_a <= 32'h5;
      run(op_signed_divide, 32'h0, 32'h0, 4'h0, 7'h60);
   endtask : t_divide

   task automatic t_event();
      program_status_flags <= 4'hF;
      run(op_send_event_hint, 32'h0, 32'h0, 4'hF, 7'h41);
      enc32 <= 1'b0;
      run(op_send_event_hint, 32'h0, 32'h0, 4'h0, 7'h41);
      cond_pass <= 1'b0;
      run(op_send_event_hint, 32'h0, 32'h0, 4'h0, 7'h40);
   endtask : t_event

   task automatic t_mul();
      {op_a, op_b, program_status_flags} <= {32'hFFFFFFFE, 32'h3, 4'hF};
      run(op_signed_mul_long, 32'hFFFFFFFF, 32'hFFFFFFFA, 4'hF, 7'h70);
      {op_a, op_b, acc_lo} <= {32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
      run(op_signed_mul_acc_long, 32'h1, 32'h0, 4'h0, 7'h70);
      {op_a, op_b, acc_hi, acc_lo} <= {32'h2, 32'h3, 32'hFFFFFFFF, 32'hFFFFFFF0};
      run(op_signed_mul_acc_long, 32'hFFFFFFFF, 32'hFFFFFFF6, 4'h0, 7'h70);
      high_result_reg <= 4'h4;
      run(op_signed_mul_long, 32'h0, 32'h0, 4'h0, 7'h04);
   endtask : t_mul

   task automatic t_misc();
      {rd, imm12, op_a} <= {REG_STACK, 12'h001, 32'h5};
      run(op_subtract_with_carry_imm, 32'h0, 32'h0, 4'h0, 7'h04);
      rm <= REG_PROG;
      run(op_signed_divide, 32'h0, 32'h0, 4'h0, 7'h04);
      imm12 <= 12'h100;
      run(op_subtract_with_carry_imm, 32'h0, 32'h0, 4'h0, 7'h04);
      {cond_pass, set_flags_bit, imm12, program_status_flags} <= {2'h1, 12'h001, 4'h2};
      run(op_subtract_with_carry_imm, 32'h0, 32'h0, 4'h2, 7'h40);
      {cond_pass, div_trap_enable} <= 2'h1;
      run(op_signed_divide, 32'h0, 32'h0, 4'h0, 7'h40);
      rn <= REG_PROG;
      run(op_signed_field_extract, 32'h0, 32'h0, 4'h0, 7'h04);
   endtask : t_misc

   task automatic final_report();
      if (errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report

   initial begin
      reset = 1'b1;
      defaults();
      repeat (5) @(posedge mclk);
      `CHK({ctl_out, res_lo_reg, flags_out_reg}, 43'h0)
      reset <= 1'b0;
      @(posedge mclk);
      t_sub_imm();
      t_sub_reg();
      t_extract();
      t_divide();
      t_event();
      t_mul();
      t_misc();
      final_report();
   end
endmodule : test_sbdmu_unit
